// >>> seq_core.sv
// standby sequencer: fetch, decode and execute of the 32 program slots
// assumes a memory slave that holds off with i_mem_ack and a software port
// Operation
// - last slot without stop or branch terminates automatically
// - word is opcode, first operand, second operand, extension, 4 bits each
// - 0000 stores low byte of reg m, 0001 loads byte into reg m
// - 0010 stores word of reg m, 0011 loads word into reg m
// - 0100 sets, 0101 clears the selected memory bit
// - 0110 copies the selected memory bit into carry
// - 0111 ext 0000 add, 0001 subtract, 0010 compare flags only
// - 0111 ext 0011 operand 0000 shifts reg n right, bit 0 to carry
// - 1000 adds displacement to step on carry or zero condition
// - 1001 waits a fixed time set by two immediate fields
// - 1010 holds step while bit is 1, 1011 while bit is 0
// - 1111 all zero clears step and halts
// - 1111 ext 0001 raises interrupt, clears step and halts
// - 1111 ext 0010 pulses transfer controller trigger and continues
// - zero flag set when add, subtract or compare result is zero
// - carry takes overflow, borrow, shifted-out bit or copied bit
//
// Implementation choices: the address-and-strobe port and the address map.
module seq_core
    import seq_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_mem_valid,
    output mem_req_t               o_mem_req,
    input  wire logic              i_mem_ack,
    input  wire logic [DATA_W-1:0] i_mem_rdata,
    output logic                   o_irq,
    output logic                   o_xfer_trigger,
    output logic                   o_running
);

    // effective byte address: register plus byte offset
    function automatic logic [MEM_AW-1:0] eff_addr(logic [DATA_W-1:0] base,
                                                   logic [3:0] ofs);
        return base + MEM_AW'(ofs[2:0]);
    endfunction

    // one-hot mask of the selected bit within a byte
    function automatic logic [7:0] bit_mask(logic [3:0] sel);
        return 8'h01 << sel[2:0];
    endfunction

    seq_state_t        state_q, state_d;
    instr_t            instr_q;
    logic [STEP_W-1:0] step_q, step_d;
    logic              carry_q, carry_d;
    logic              zero_q, zero_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic              rmw_q, rmw_d;
    logic              mem_valid_q, mem_valid_d;
    mem_req_t          mem_q, mem_d;
    logic              irq_q, irq_d;
    logic              xfer_q, xfer_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] gr_q [GR_CNT];
    logic              gr_we;
    logic [GR_IW-1:0]  gr_widx;
    logic [DATA_W-1:0] gr_wdata;

    // software port decode
    logic              hit_slot;
    logic              hit_gr;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              start_req;
    logic              abort_req;
    logic [DATA_W-1:0] slot_rd;
    logic [DATA_W-1:0] slot_bus_rd;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] rd_mux;

    assign hit_slot  = (i_addr < ADDR_W'(SLOT_CNT));
    assign hit_gr    = (i_addr[ADDR_W-1:GR_IW] == REG_GR_BASE[ADDR_W-1:GR_IW]);
    assign hit_ctrl  = (i_addr == REG_CTRL);
    assign hit_stat  = (i_addr == REG_STATUS);
    assign start_req = i_wr && hit_ctrl && i_wdata[CTRL_START_BIT];
    assign abort_req = i_wr && hit_ctrl && i_wdata[CTRL_ABORT_BIT];

    // status shows the block's own state and flags
    always_comb
    begin
        stat_word = '0;
        stat_word[STAT_RUN_BIT] = o_running;
        stat_word[STAT_CY_BIT]  = carry_q;
        stat_word[STAT_Z_BIT]   = zero_q;
        stat_word[STAT_STEP_LSB +: STEP_W] = step_q;
    end

    // unmapped addresses read as zero
    assign rd_mux = hit_slot ? slot_bus_rd
                  : hit_gr   ? gr_q[i_addr[GR_IW-1:0]]
                  : hit_stat ? stat_word
                  : '0;

    seq_slot_store #(
        .DEPTH (SLOT_CNT),
        .WIDTH (DATA_W),
        .IW    (STEP_W)
    ) u_slots (
        .i_mclk    (i_mclk),
        .i_srst    (i_srst),
        .i_wr      (i_wr && hit_slot),
        .i_widx    (i_addr[STEP_W-1:0]),
        .i_wdata   (i_wdata),
        .i_ridx_a  (step_q),
        .o_rdata_a (slot_rd),
        .i_ridx_b  (i_addr[STEP_W-1:0]),
        .o_rdata_b (slot_bus_rd)
    );

    // instruction fields and operand registers
    logic [DATA_W-1:0] reg_n;
    logic [DATA_W-1:0] reg_m;
    logic [MEM_AW-1:0] ea;
    logic              mem_bit;
    logic [7:0]        rmw_byte;
    logic              op_mem;
    logic              op_store;
    logic              op_word;
    logic              is_last;
    logic [STEP_W-1:0] adv_step;
    seq_state_t        adv_state;
    logic              br_cond;
    logic              alu_legal;
    logic              ctrl_opnd;

    assign reg_n    = gr_q[instr_q.fn];
    assign reg_m    = gr_q[instr_q.fm];
    assign ea       = eff_addr(reg_n, instr_q.fx);
    assign mem_bit  = |(i_mem_rdata[7:0] & bit_mask(instr_q.fm));
    assign rmw_byte = (instr_q.opc == OPC_BSET)
                    ? (i_mem_rdata[7:0] | bit_mask(instr_q.fm))
                    : (i_mem_rdata[7:0] & ~bit_mask(instr_q.fm));
    assign op_mem   = (instr_q.opc <= OPC_BTST) || (instr_q.opc == OPC_WAIT1)
                   || (instr_q.opc == OPC_WAIT0);
    assign op_store = (instr_q.opc == OPC_ST_B) || (instr_q.opc == OPC_ST_W);
    assign op_word  = (instr_q.opc == OPC_ST_W) || (instr_q.opc == OPC_LD_W);

    // normal advance; the last slot falls into termination
    assign is_last   = (step_q == STEP_LAST);
    assign adv_step  = is_last ? STEP_FIRST : (step_q + STEP_ONE);
    assign adv_state = is_last ? S_IDLE : S_FETCH;

    // branch condition from the extension field
    assign br_cond = ((instr_q.fx == EXT_BCY1) && carry_q)
                  || ((instr_q.fx == EXT_BCY0) && !carry_q)
                  || ((instr_q.fx == EXT_BZ1) && zero_q)
                  || ((instr_q.fx == EXT_BZ0) && !zero_q);

    assign alu_legal = (instr_q.fx == EXT_ADD) || (instr_q.fx == EXT_SUB)
                    || (instr_q.fx == EXT_CMP)
                    || ((instr_q.fx == EXT_SHR) && (instr_q.fm == OPND_NONE));
    assign ctrl_opnd = (instr_q.fn == OPND_NONE) && (instr_q.fm == OPND_NONE);

    logic [DATA_W-1:0] alu_res;
    logic              alu_cy;
    logic              alu_z;
    logic              alu_wr;
    logic              alu_zu;

    seq_alu u_alu (
        .i_a        (reg_n),
        .i_b        (reg_m),
        .i_ext      (instr_q.fx),
        .o_res      (alu_res),
        .o_carry    (alu_cy),
        .o_zero     (alu_z),
        .o_wr_reg   (alu_wr),
        .o_zero_upd (alu_zu)
    );

    // next-state logic of the execute sequence
    always_comb
    begin
        state_d     = state_q;
        step_d      = step_q;
        carry_d     = carry_q;
        zero_d      = zero_q;
        timer_d     = timer_q;
        rmw_d       = rmw_q;
        mem_valid_d = mem_valid_q;
        mem_d       = mem_q;
        irq_d       = 1'b0;
        xfer_d      = 1'b0;
        gr_we       = 1'b0;
        gr_widx     = instr_q.fn;
        gr_wdata    = alu_res;
        unique case (state_q)
            S_IDLE:
                if (start_req)
                    state_d = S_FETCH;
            S_FETCH:
                state_d = S_EXEC;
            S_EXEC:
                if (op_mem)
                begin
                    mem_valid_d = 1'b1;
                    mem_d.we    = op_store;
                    mem_d.word  = op_word;
                    mem_d.addr  = ea;
                    mem_d.wdata = op_word ? reg_m : {8'h00, reg_m[7:0]};
                    rmw_d       = (instr_q.opc == OPC_BSET) || (instr_q.opc == OPC_BCLR);
                    state_d     = S_MEM;
                end
                else if (instr_q.opc == OPC_ALU && alu_legal)
                begin
                    gr_we   = alu_wr;
                    carry_d = alu_cy;
                    zero_d  = alu_zu ? alu_z : zero_q;
                    step_d  = adv_step;
                    state_d = adv_state;
                end
                else if (instr_q.opc == OPC_BRANCH && br_cond)
                begin
                    // low five bits of the signed displacement wrap the step
                    step_d  = step_q + {instr_q.fn[0], instr_q.fm};
                    state_d = S_FETCH;
                end
                else if (instr_q.opc == OPC_BRANCH)
                begin
                    // untaken branch in the last slot wraps, no auto stop
                    step_d  = step_q + STEP_ONE;
                    state_d = S_FETCH;
                end
                else if (instr_q.opc == OPC_WAIT)
                begin
                    timer_d = {instr_q.fm, instr_q.fx};
                    state_d = S_TIMER;
                end
                else if (instr_q.opc == OPC_CTRL && ctrl_opnd
                         && (instr_q.fx == EXT_STOP || instr_q.fx == EXT_IRQ))
                begin
                    irq_d   = (instr_q.fx == EXT_IRQ);
                    step_d  = STEP_FIRST;
                    state_d = S_IDLE;
                end
                else
                begin
                    // transfer trigger and reserved codes both advance
                    xfer_d  = (instr_q.opc == OPC_CTRL) && ctrl_opnd
                           && (instr_q.fx == EXT_XFER);
                    step_d  = adv_step;
                    state_d = adv_state;
                end
            S_MEM:
                if (i_mem_ack && rmw_q)
                begin
                    // second half of a bit update: write the byte back
                    mem_d.we    = 1'b1;
                    mem_d.wdata = {8'h00, rmw_byte};
                    rmw_d       = 1'b0;
                end
                else if (i_mem_ack)
                begin
                    mem_valid_d = 1'b0;
                    gr_widx     = instr_q.fm;
                    gr_wdata    = op_word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                    gr_we       = (instr_q.opc == OPC_LD_B) || (instr_q.opc == OPC_LD_W);
                    if (instr_q.opc == OPC_BTST)
                        carry_d = mem_bit;
                    if ((instr_q.opc == OPC_WAIT1 && mem_bit)
                        || (instr_q.opc == OPC_WAIT0 && !mem_bit))
                        state_d = S_EXEC;
                    else
                    begin
                        step_d  = adv_step;
                        state_d = adv_state;
                    end
                end
            S_TIMER:
                if (timer_q == TIMER_ZERO)
                begin
                    step_d  = adv_step;
                    state_d = adv_state;
                end
                else
                    timer_d = timer_q - TIMER_W'(STEP_ONE);
            default:
                state_d = S_IDLE;
        endcase
        // abort may abandon a pending memory access
        if (abort_req)
        begin
            state_d     = S_IDLE;
            step_d      = STEP_FIRST;
            mem_valid_d = 1'b0;
            rmw_d       = 1'b0;
        end
    end

    // sequencer state and flags
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state_q     <= S_IDLE;
            step_q      <= STEP_FIRST;
            carry_q     <= 1'b0;
            zero_q      <= 1'b0;
            timer_q     <= TIMER_ZERO;
            rmw_q       <= 1'b0;
            mem_valid_q <= 1'b0;
            mem_q       <= '0;
            irq_q       <= 1'b0;
            xfer_q      <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            step_q      <= step_d;
            carry_q     <= carry_d;
            zero_q      <= zero_d;
            timer_q     <= timer_d;
            rmw_q       <= rmw_d;
            mem_valid_q <= mem_valid_d;
            mem_q       <= mem_d;
            irq_q       <= irq_d;
            xfer_q      <= xfer_d;
        end
    end

    // instruction latch, decoded per its fixed field layout
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            instr_q <= '0;
        else if (state_q == S_FETCH)
            instr_q <= instr_t'(slot_rd);
    end

    // general registers: sequencer write beats a software write
    always_ff @(posedge i_mclk)
    begin
        for (int i = 0; i < GR_CNT; i++)
        begin
            if (i_srst)
                gr_q[i] <= GR_RESET;
            else if (gr_we && gr_widx == GR_IW'(i))
                gr_q[i] <= gr_wdata;
            else if (i_wr && hit_gr && i_addr[GR_IW-1:0] == GR_IW'(i))
                gr_q[i] <= i_wdata;
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || !i_rd)
            rdata_q <= '0;
        else
            rdata_q <= rd_mux;
    end

    assign o_rdata        = rdata_q;
    assign o_mem_valid    = mem_valid_q;
    assign o_mem_req      = mem_q;
    assign o_irq          = irq_q;
    assign o_xfer_trigger = xfer_q;
    assign o_running      = (state_q != S_IDLE);

endmodule

// >>> seq_pkg.sv
// constants, encodings and carrier types of the standby sequencer
// assumes one clock domain and a simple memory master port outside
package seq_pkg;

    // widths and sizes
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 8;
    localparam int MEM_AW   = 16;
    localparam int SLOT_CNT = 32;
    localparam int STEP_W   = 5;
    localparam int GR_CNT   = 16;
    localparam int GR_IW    = 4;
    localparam int TIMER_W  = 8;

    // register map of the software port
    localparam logic [ADDR_W-1:0] REG_SLOT_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h20;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h21;
    localparam logic [ADDR_W-1:0] REG_GR_BASE   = 8'h30;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_CY_BIT    = 1;
    localparam int STAT_Z_BIT     = 2;
    localparam int STAT_STEP_LSB  = 8;

    // reset values and fixed step values
    localparam logic [DATA_W-1:0] SLOT_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] GR_RESET   = 16'h0000;
    localparam logic [STEP_W-1:0] STEP_FIRST = 5'h00;
    localparam logic [STEP_W-1:0] STEP_LAST  = 5'h1f;
    localparam logic [STEP_W-1:0] STEP_ONE   = 5'h01;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;

    // operation codes
    localparam logic [3:0] OPC_ST_B   = 4'h0;
    localparam logic [3:0] OPC_LD_B   = 4'h1;
    localparam logic [3:0] OPC_ST_W   = 4'h2;
    localparam logic [3:0] OPC_LD_W   = 4'h3;
    localparam logic [3:0] OPC_BSET   = 4'h4;
    localparam logic [3:0] OPC_BCLR   = 4'h5;
    localparam logic [3:0] OPC_BTST   = 4'h6;
    localparam logic [3:0] OPC_ALU    = 4'h7;
    localparam logic [3:0] OPC_BRANCH = 4'h8;
    localparam logic [3:0] OPC_WAIT   = 4'h9;
    localparam logic [3:0] OPC_WAIT1  = 4'ha;
    localparam logic [3:0] OPC_WAIT0  = 4'hb;
    localparam logic [3:0] OPC_CTRL   = 4'hf;

    // extension codes
    localparam logic [3:0] EXT_ADD  = 4'h0;
    localparam logic [3:0] EXT_SUB  = 4'h1;
    localparam logic [3:0] EXT_CMP  = 4'h2;
    localparam logic [3:0] EXT_SHR  = 4'h3;
    localparam logic [3:0] EXT_BCY1 = 4'h0;
    localparam logic [3:0] EXT_BCY0 = 4'h1;
    localparam logic [3:0] EXT_BZ1  = 4'h2;
    localparam logic [3:0] EXT_BZ0  = 4'h3;
    localparam logic [3:0] EXT_STOP = 4'h0;
    localparam logic [3:0] EXT_IRQ  = 4'h1;
    localparam logic [3:0] EXT_XFER = 4'h2;
    localparam logic [3:0] OPND_NONE = 4'h0;

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_FETCH = 5'b00010,
        S_EXEC  = 5'b00100,
        S_MEM   = 5'b01000,
        S_TIMER = 5'b10000
    } seq_state_t;

    // one memory request, held until acknowledged
    typedef struct packed {
        logic              we;
        logic              word;
        logic [MEM_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    // decoded instruction word
    typedef struct packed {
        logic [3:0] opc;
        logic [3:0] fn;
        logic [3:0] fm;
        logic [3:0] fx;
    } instr_t;

endpackage

// >>> seq_slot_store.sv
// instruction slot store: flip-flop array, one write port, two read ports
// assumes writes come only from software while the sequencer is halted
module seq_slot_store
    import seq_pkg::*;
#(
    parameter int DEPTH = SLOT_CNT,
    parameter int WIDTH = DATA_W,
    parameter int IW    = STEP_W
)(
    input  wire logic             i_mclk,
    input  wire logic             i_srst,
    input  wire logic             i_wr,
    input  wire logic [IW-1:0]    i_widx,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic [IW-1:0]    i_ridx_a,
    output logic      [WIDTH-1:0] o_rdata_a,
    input  wire logic [IW-1:0]    i_ridx_b,
    output logic      [WIDTH-1:0] o_rdata_b
);

    logic [WIDTH-1:0] slot_q [DEPTH];

    // reads are plain selections of the stored flops
    assign o_rdata_a = slot_q[i_ridx_a];
    assign o_rdata_b = slot_q[i_ridx_b];

    // slots cleared at reset so a fresh start never sees x
    always_ff @(posedge i_mclk)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (i_srst)
                slot_q[i] <= WIDTH'(SLOT_RESET);
            else if (i_wr && (i_widx == IW'(i)))
                slot_q[i] <= i_wdata;
        end
    end

endmodule

// >>> seq_alu.sv
// word arithmetic of the sequencer: add, subtract, compare, shift right
// purely combinational, the caller owns the flags and registers
module seq_alu
    import seq_pkg::*;
(
    input  wire logic [DATA_W-1:0] i_a,
    input  wire logic [DATA_W-1:0] i_b,
    input  wire logic [3:0]        i_ext,
    output logic      [DATA_W-1:0] o_res,
    output logic                   o_carry,
    output logic                   o_zero,
    output logic                   o_wr_reg,
    output logic                   o_zero_upd
);

    logic [DATA_W:0] sum;
    logic [DATA_W:0] diff;

    // one extra bit catches overflow and borrow
    assign sum  = {1'b0, i_a} + {1'b0, i_b};
    assign diff = {1'b0, i_a} - {1'b0, i_b};

    // compare shares the subtractor but never writes back
    assign o_res      = (i_ext == EXT_ADD) ? sum[DATA_W-1:0]
                      : (i_ext == EXT_SHR) ? (i_a >> 1)
                      : diff[DATA_W-1:0];
    assign o_carry    = (i_ext == EXT_ADD) ? sum[DATA_W]
                      : (i_ext == EXT_SHR) ? i_a[0]
                      : diff[DATA_W];
    assign o_zero     = (o_res == GR_RESET);
    assign o_wr_reg   = (i_ext != EXT_CMP);
    assign o_zero_upd = (i_ext != EXT_SHR);

endmodule

// >>> seq_mem_model.sv
// memory slave facing the sequencer core: byte array, random stalls
// assumes one request at a time, held by the core until acknowledged
module seq_mem_model
    import seq_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_srst,
    input  wire logic              i_valid,
    input  wire mem_req_t          i_req,
    output logic                   o_ack,
    output logic      [DATA_W-1:0] o_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:255];
    logic       go_q;
    wire  [7:0] a0 = i_req.addr[7:0];
    wire  [7:0] a1 = a0 + 8'h01;
    // ack only while the request stands, so an abort leaves nothing
    assign o_ack = go_q && i_valid;
    // byte reads carry junk above bit 7; idle lines never hold old data
    assign o_rdata = o_ack ? {i_req.word ? mem[a1] : ~mem[a0], mem[a0]}
                           : ~{mem[a1], mem[a0]};
    // stall of random length, write lands on the acknowledging edge
    always @(posedge i_mclk)
    begin
        go_q <= !i_srst && i_valid && !o_ack && ($urandom % 2 == 0);
        if (o_ack && i_req.we)
        begin
            mem[a0] <= i_req.wdata[7:0];
            if (i_req.word)
                mem[a1] <= i_req.wdata[15:8];
        end
    end
endmodule

// >>> seq_core_chk.sv
// port checker of the sequencer core
// bound into seq_core, one clock, synchronous active-high reset
module seq_core_chk
    import seq_pkg::*;
(
    input wire logic              i_mclk,
    input wire logic              i_srst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              o_mem_valid,
    input wire mem_req_t          o_mem_req,
    input wire logic              i_mem_ack,
    input wire logic              o_irq,
    input wire logic              o_xfer_trigger,
    input wire logic              o_running
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // control writes; an abort may drop a pending request
    wire ctl = i_wr && i_addr == REG_CTRL;
    wire go  = ctl && i_wdata[CTRL_START_BIT] && !i_wdata[CTRL_ABORT_BIT];
    sequence s_stall; o_mem_valid && !i_mem_ack && !ctl; endsequence
    sequence s_halt; ##[0:1] !o_running; endsequence
    property p_req_hold; s_stall |=> o_mem_valid && $stable(o_mem_req); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved");
    property p_mem_run; o_mem_valid |-> o_running; endproperty
    a_mem_run: assert property (p_mem_run) else $error("request while idle");
    property p_idle; !o_running && !(ctl && i_wdata[0]) |=> !o_running; endproperty
    a_idle: assert property (p_idle) else $error("woke unasked");
    property p_start; go && !o_running |=> o_running; endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_irq_pulse; o_irq |=> !o_irq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    property p_irq_halt; o_irq |-> s_halt; endproperty
    a_irq_halt: assert property (p_irq_halt) else $error("no halt on irq");
    property p_xfer; o_xfer_trigger |=> !o_xfer_trigger; endproperty
    a_xfer: assert property (p_xfer) else $error("trigger too long");
    property p_unmap; i_rd && i_addr >= 8'h40 |=> o_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule

bind seq_core seq_core_chk chk_u (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_valid(o_mem_valid),
    .o_mem_req(o_mem_req), .i_mem_ack(i_mem_ack), .o_irq(o_irq),
    .o_xfer_trigger(o_xfer_trigger), .o_running(o_running));

// >>> standby_sequencer_instruction_exec_test.sv
// self-checking bench of the sequencer core with a random memory slave
// assumes seq_pkg, seq_core, seq_mem_model and the bound checker
module standby_sequencer_instruction_exec_test
    import seq_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wd = 16'h0000;
    logic              wr = 1'b0;
    logic              rd_s = 1'b0;
    logic [DATA_W-1:0] rdat, mdat, g1, g2, g3, g6, g7;
    logic [16:0]       s1, s2;
    logic [7:0]        b0;
    mem_req_t          req;
    logic              mv, ack, irq, xfer, run_s;
    int                num_errors = 0;
    int                checks_done = 0;
    int                irq_n = 0;
    int                xfer_n = 0;
    always #2.5 clk = ~clk;
    seq_core dut_u (.i_mclk(clk), .i_srst(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr),
        .i_rd(rd_s), .o_rdata(rdat), .o_mem_valid(mv), .o_mem_req(req), .i_mem_ack(ack),
        .i_mem_rdata(mdat), .o_irq(irq), .o_xfer_trigger(xfer), .o_running(run_s));
    seq_mem_model mem_u (.i_mclk(clk), .i_srst(rst), .i_valid(mv), .i_req(req),
        .o_ack(ack), .o_rdata(mdat));
    // event pulses counted, a stretched pulse shows up as extra counts
    always @(posedge clk)
    begin
        irq_n <= irq_n + int'(irq === 1'b1);
        xfer_n <= xfer_n + int'(xfer === 1'b1);
    end
    function automatic logic [15:0] stat(input logic cy, input logic z);
        stat = 16'h0000;
        stat[STAT_CY_BIT] = cy;
        stat[STAT_Z_BIT] = z;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(rdat, exp);
    endtask
    // start and wait for the halt, bounded
    task automatic go_wait();
        int n;
        n = 0;
        wr_reg(REG_CTRL, 16'h0001);
        #1;
        while (run_s === 1'b1 && n < 600)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check({15'h0000, run_s}, 16'h0000);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        num_errors++;
        results();
    end
    initial
    begin
        logic [15:0] prog [8] = '{16'h2122, 16'h3142, 16'h7230, 16'h4150,
                                  16'h1150, 16'h7303, 16'hf002, 16'hf001};
        void'($urandom(42681));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(REG_SLOT_BASE, 16'h0000);
        rd_reg(REG_STATUS, 16'h0000);
        rd_reg(8'h40, 16'h0000);
        $display("reset test done");
        // transfers, bit set, add, shift, trigger, irq stop
        g1 = {8'h00, 4'($urandom), 4'h0};
        g2 = 16'($urandom);
        g3 = 16'($urandom);
        b0 = 8'($urandom) & 8'hdf;
        mem_u.mem[g1[7:0]] = b0;
        wr_reg(REG_GR_BASE + 8'h01, g1);
        wr_reg(REG_GR_BASE + 8'h02, g2);
        wr_reg(REG_GR_BASE + 8'h03, g3);
        foreach (prog[i]) wr_reg(REG_SLOT_BASE + 8'(i), prog[i]);
        go_wait();
        s1 = {1'b0, g2} + {1'b0, g3};
        rd_reg(REG_GR_BASE + 8'h04, g2);
        rd_reg(REG_GR_BASE + 8'h02, s1[15:0]);
        rd_reg(REG_GR_BASE + 8'h03, g3 >> 1);
        rd_reg(REG_GR_BASE + 8'h05, {8'h00, b0 | 8'h20});
        rd_reg(REG_STATUS, stat(g3[0], s1[15:0] == 16'h0000));
        check(16'(irq_n), 16'h0001);
        check(16'(xfer_n), 16'h0001);
        $display("program test done");
        // bit test, untaken and taken branch, waits, sub, auto stop after slot 31
        g6 = 16'($urandom);
        g7 = 16'hffff - 16'($urandom % 4);
        wr_reg(REG_GR_BASE + 8'h06, g6);
        wr_reg(REG_GR_BASE + 8'h07, g7);
        prog = '{16'h6150, 16'h8051, 16'h9003, 16'hb150, 16'h7662, 16'h8192, 0, 0};
        for (int i = 0; i < 6; i++) wr_reg(REG_SLOT_BASE + 8'(i), prog[i]);
        wr_reg(REG_SLOT_BASE + 8'h1e, 16'h7671);
        wr_reg(REG_SLOT_BASE + 8'h1f, 16'h7670);
        go_wait();
        s1 = {1'b0, g6} - {1'b0, g7};
        s2 = {1'b0, s1[15:0]} + {1'b0, g7};
        rd_reg(REG_GR_BASE + 8'h06, s2[15:0]);
        rd_reg(REG_STATUS, stat(s2[16], s2[15:0] == 16'h0000));
        check(16'(irq_n), 16'h0001);
        $display("branch test done");
        results();
    end
endmodule
